/* bench/test_usb_endpoint_status_flags.sv */
// Self-checking bench for the endpoint status flag block
`timescale 1ns/1ps
module test_usb_endpoint_status_flags
  import usb_ep_pkg::*;
;
  logic              ref_clk = 1'b0;
  logic              rst_n = 1'b0;
  logic [REG_AW-1:0] reg_addr = 2'h0;
  logic [REG_DW-1:0] reg_wdata = 8'h00;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic [REG_DW-1:0] reg_rdata;
  logic              go = 1'b0;
  logic [2:0]        kind = 3'h0;
  logic              arg = 1'b0;
  logic [7:0]        ev;
  logic              bank, crc, nak, fifo_ok, stall_en, rdy, irq;
  logic [7:0]        lfsr = 8'h25;
  logic              any_crc = 1'b0;
  int                error_cnt = 0;
  int                compares = 0;

  always #50 ref_clk = ~ref_clk;

  usb_host_model usb_host_model_inst (.ref_clk(ref_clk), .go(go), .kind(kind), .arg(arg),
    .ev(ev), .bank(bank), .crc(crc));
  usb_endpoint_status_flags usb_endpoint_status_flags_inst (.ref_clk(ref_clk),
    .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .setup_rx_ok(ev[0]), .setup_token(ev[1]),
    .data_rx_done(ev[2]), .data_crc_err(crc), .out_stored(ev[3]), .out_stored_bank(bank),
    .out_token(ev[4]), .out_token_bank(bank), .in_sent(ev[5]), .in_acked(ev[6]),
    .stall_sent(ev[7]), .out_nak(nak), .setup_fifo_write_ok(fifo_ok),
    .stall_handshake_en(stall_en), .in_packet_ready(rdy), .irq(irq));

  // Next pseudo-random byte, repeatable from the fixed start value
  function automatic logic [7:0] lfsr_nxt(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  // Iso status: crc flag, bank 0 flag, optional IN complete
  function automatic logic [7:0] iso_st(input logic c, input logic tx);
    return {4'h0, c, 2'b01, tx};
  endfunction

  task automatic close_out;
    if (error_cnt == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", e, reg_rdata);
  endtask
  // Returns while the pulse stands, so steering outputs can be sampled
  task automatic pulse(input logic [2:0] k, input logic a);
    @(posedge ref_clk);
    go <= 1'b1;
    kind <= k;
    arg <= a;
    @(posedge ref_clk);
    go <= 1'b0;
    #1;
  endtask

  initial
  begin
    #2000000;
    error_cnt++;
    close_out;
  end

  initial
  begin
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++)
      rd(2'(i), 8'h00);
    wr(MASK_ADDR, 8'h7F);
    rd(MASK_ADDR, 8'h7F);
    // Bulk: bank 0 back-pressure and interrupt masking
    wr(CONFIG_ADDR, 8'h02);
    pulse(3'd3, 1'b0);
    pulse(3'd4, 1'b0);
    chk("out_nak", 8'h01, {7'h00, nak});
    rd(STATUS_ADDR, 8'h02);
    chk("irq", 8'h01, {7'h00, irq});
    wr(MASK_ADDR, 8'h00);
    chk("irq", 8'h00, {7'h00, irq});
    wr(MASK_ADDR, 8'h7F);
    rd(EVENT_ADDR, 8'h02);
    @(posedge ref_clk);
    #1 chk("irq", 8'h00, {7'h00, irq});
    wr(STATUS_ADDR, 8'hCD);
    pulse(3'd4, 1'b0);
    chk("out_nak", 8'h00, {7'h00, nak});
    // Ping-pong: bank 1 blocks only its own bank
    wr(CONFIG_ADDR, 8'h06);
    pulse(3'd3, 1'b1);
    pulse(3'd4, 1'b1);
    chk("out_nak", 8'h01, {7'h00, nak});
    pulse(3'd4, 1'b0);
    chk("out_nak", 8'h00, {7'h00, nak});
    rd(STATUS_ADDR, 8'h40);
    wr(STATUS_ADDR, 8'h00);
    // Iso: no NAK, crc flag follows each packet at random
    wr(CONFIG_ADDR, 8'h01);
    pulse(3'd3, 1'b0);
    pulse(3'd4, 1'b0);
    chk("out_nak", 8'h00, {7'h00, nak});
    for (int i = 0; i < 6; i++)
    begin
      lfsr = lfsr_nxt(lfsr);
      any_crc |= lfsr[0];
      pulse(3'd2, lfsr[0]);
      rd(STATUS_ADDR, iso_st(lfsr[0], 1'b0));
    end
    // Corner: error flag high, then a firmware write of zero to it
    pulse(3'd2, 1'b1);
    any_crc = 1'b1;
    wr(STATUS_ADDR, 8'h02);
    rd(STATUS_ADDR, iso_st(1'b1, 1'b0));
    pulse(3'd6, 1'b0);
    rd(STATUS_ADDR, iso_st(1'b1, 1'b0));
    pulse(3'd5, 1'b0);
    rd(STATUS_ADDR, iso_st(1'b1, 1'b1));
    rd(EVENT_ADDR, iso_st(any_crc, 1'b1) | 8'h40);
    // Bulk: IN needs ACK, stall only when requested, SETUP wipes the rest
    wr(CONFIG_ADDR, 8'h02);
    wr(STATUS_ADDR, 8'h0A);
    rd(STATUS_ADDR, 8'h0A);
    wr(STATUS_ADDR, 8'h10);
    rd(STATUS_ADDR, 8'h10);
    pulse(3'd5, 1'b0);
    rd(STATUS_ADDR, 8'h10);
    pulse(3'd6, 1'b0);
    rd(STATUS_ADDR, 8'h01);
    chk("in_packet_ready", 8'h00, {7'h00, rdy});
    pulse(3'd7, 1'b0);
    rd(STATUS_ADDR, 8'h01);
    wr(STATUS_ADDR, 8'h21);
    chk("stall_handshake_en", 8'h01, {7'h00, stall_en});
    pulse(3'd7, 1'b0);
    rd(STATUS_ADDR, 8'h29);
    wr(STATUS_ADDR, 8'h28);
    wr(STATUS_ADDR, 8'h38);
    rd(STATUS_ADDR, 8'h38);
    pulse(3'd1, 1'b0);
    chk("setup_fifo_write_ok", 8'h00, {7'h00, fifo_ok});
    pulse(3'd0, 1'b0);
    rd(STATUS_ADDR, 8'h04);
    chk("stall_handshake_en", 8'h00, {7'h00, stall_en});
    chk("in_packet_ready", 8'h00, {7'h00, rdy});
    rd(EVENT_ADDR, 8'h0D);
    wr(STATUS_ADDR, 8'h00);
    rd(STATUS_ADDR, 8'h00);
    wr(CONFIG_ADDR, 8'h00);
    pulse(3'd1, 1'b0);
    chk("setup_fifo_write_ok", 8'h01, {7'h00, fifo_ok});
    // Interrupt type: no SETUP bypass, bank 0 back-pressure as bulk
    wr(CONFIG_ADDR, 8'h03);
    pulse(3'd1, 1'b0);
    chk("setup_fifo_write_ok", 8'h00, {7'h00, fifo_ok});
    pulse(3'd3, 1'b0);
    pulse(3'd4, 1'b0);
    chk("out_nak", 8'h01, {7'h00, nak});
    close_out;
  end
endmodule // test_usb_endpoint_status_flags

/* bench/usb_ep_flags_properties.sv */
// Port-level checker for the endpoint status flag block
`timescale 1ns/1ps
module usb_ep_flags_properties
  import usb_ep_pkg::*;
(
  input wire logic              ref_clk,
  input wire logic              rst_n,
  input wire logic [REG_AW-1:0] reg_addr,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic              setup_rx_ok,
  input wire logic              setup_token,
  input wire logic              data_rx_done,
  input wire logic              out_stored,
  input wire logic              out_token,
  input wire logic              in_sent,
  input wire logic              in_acked,
  input wire logic              stall_sent,
  input wire logic              out_nak,
  input wire logic              setup_fifo_write_ok,
  input wire logic              stall_handshake_en,
  input wire logic              in_packet_ready,
  input wire logic              irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // A SETUP wipes both firmware-owned control bits on the next edge
  a_setup_clr_stall: assert property (setup_rx_ok |=> !stall_handshake_en)
    else $error("stall request survived a SETUP");
  a_setup_clr_ready: assert property (setup_rx_ok |=> !in_packet_ready)
    else $error("packet ready survived a SETUP");
  // Steering outputs only answer a token that is present now
  a_nak_needs_token: assert property (out_nak |-> out_token)
    else $error("NAK without an OUT token");
  a_fifo_needs_token: assert property (setup_fifo_write_ok |-> setup_token)
    else $error("SETUP FIFO write without a SETUP token");
  // Control bits move only for a firmware write, a SETUP or a finished transfer
  a_ready_fall_cause: assert property ($fell(in_packet_ready)
    |-> $past(in_sent | in_acked | setup_rx_ok | reg_wr))
    else $error("packet ready fell without a cause");
  a_ready_rise_cause: assert property ($rose(in_packet_ready)
    |-> $past(reg_wr && reg_addr == STATUS_ADDR))
    else $error("packet ready rose without a status write");
  a_stall_rise_cause: assert property ($rose(stall_handshake_en)
    |-> $past(reg_wr && reg_addr == STATUS_ADDR))
    else $error("stall request rose without a status write");
  // The interrupt follows an event or a register access by one cycle
  a_irq_rise_cause: assert property ($rose(irq) |-> $past(setup_rx_ok | data_rx_done
    | out_stored | in_sent | in_acked | stall_sent | reg_wr))
    else $error("interrupt rose without an event");
  a_irq_fall_cause: assert property ($fell(irq) |-> $past(reg_rd | reg_wr))
    else $error("interrupt fell without a register access");
endmodule // usb_ep_flags_properties

bind usb_endpoint_status_flags usb_ep_flags_properties usb_ep_flags_properties_inst (
  .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .setup_rx_ok(setup_rx_ok), .setup_token(setup_token), .data_rx_done(data_rx_done),
  .out_stored(out_stored), .out_token(out_token), .in_sent(in_sent), .in_acked(in_acked),
  .stall_sent(stall_sent), .out_nak(out_nak), .setup_fifo_write_ok(setup_fifo_write_ok),
  .stall_handshake_en(stall_handshake_en), .in_packet_ready(in_packet_ready), .irq(irq));

/* bench/usb_host_model.sv */
// Serial engine and host side model: one command becomes one event pulse
`timescale 1ns/1ps
module usb_host_model (
  input  wire logic       ref_clk,
  input  wire logic       go,
  input  wire logic [2:0] kind,
  input  wire logic       arg,
  output logic      [7:0] ev,
  output logic            bank,
  output logic            crc
);
  initial
  begin
    ev = 8'h00;
    bank = 1'b0;
    crc = 1'b0;
  end
  // Idle qualifiers flip every cycle so a stale value never passes as valid
  always @(posedge ref_clk)
  begin
    ev <= go ? (8'h01 << kind) : 8'h00;
    bank <= go ? arg : ~bank;
    crc <= go ? arg : ~crc;
  end
endmodule // usb_host_model

/* hdl/irq_gate.sv */
// Interrupt mask register and level interrupt output
`timescale 1ns/1ps
module irq_gate
  import usb_ep_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              mask_wr,
  input  wire logic [REG_DW-1:0] mask_wdata,
  input  wire logic [REG_DW-1:0] event_bits,
  output logic      [REG_DW-1:0] mask_r,
  output logic                   irq
);

  // Mask written whole by software
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      mask_r <= MASK_RST;
    else if (mask_wr)
      mask_r <= mask_wdata;
  end

  // Level output, both terms come from flip-flops
  assign irq = |(event_bits & mask_r);

endmodule // irq_gate

/* hdl/sticky_bits.sv */
// Vector of sticky event bits, hardware set wins over a clear
`timescale 1ns/1ps
module sticky_bits
  import usb_ep_pkg::*;
#(
  parameter int W = 8
)(
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] set_bits,
  input  wire logic         clear_all,
  output logic      [W-1:0] bits_r
);

  // An event landing in the clearing cycle survives the clear
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      bits_r <= '0;
    else if (clear_all)
      bits_r <= set_bits;
    else
      bits_r <= bits_r | set_bits;
  end

endmodule // sticky_bits

/* hdl/usb_endpoint_status_flags.sv */
// Endpoint status flags, NAK back-pressure and interrupt for one endpoint
//
// The address-and-strobe port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module usb_endpoint_status_flags
  import usb_ep_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  // Register port
  input  wire logic [REG_AW-1:0] reg_addr,
  input  wire logic [REG_DW-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [REG_DW-1:0] reg_rdata,
  // Transaction events from the serial engine
  input  wire logic              setup_rx_ok,
  input  wire logic              setup_token,
  input  wire logic              data_rx_done,
  input  wire logic              data_crc_err,
  input  wire logic              out_stored,
  input  wire logic              out_stored_bank,
  input  wire logic              out_token,
  input  wire logic              out_token_bank,
  input  wire logic              in_sent,
  input  wire logic              in_acked,
  input  wire logic              stall_sent,
  // Handshake steering toward the serial engine
  output logic                   out_nak,
  output logic                   setup_fifo_write_ok,
  output logic                   stall_handshake_en,
  output logic                   in_packet_ready,
  // Interrupt
  output logic                   irq
);

  // Status flags
  logic                 stall_sent_crc_flag_r;
  logic                 setup_received_flag_r;
  logic                 out_bank0_received_flag_r;
  logic                 out_bank1_received_flag_r;
  logic                 in_transmit_complete_flag_r;
  logic                 in_packet_ready_bit_r;
  logic                 stall_request_bit_r;

  // Configuration
  ep_type_t             ep_type_r;
  logic                 ping_pong_r;

  // Decoded strobes and qualified events
  logic                 is_iso;
  logic                 is_control;
  logic                 status_wr;
  logic                 config_wr;
  logic                 mask_wr;
  logic                 event_rd;
  logic                 setup_set;
  logic                 stall_set;
  logic                 crc_update;
  logic                 crc_rise;
  logic                 b0_set;
  logic                 b1_set;
  logic                 in_done;
  logic [REG_DW-1:0]    event_set;
  logic [REG_DW-1:0]    event_r;
  logic [REG_DW-1:0]    mask_r;
  logic [REG_DW-1:0]    status_view;
  logic [REG_DW-1:0]    config_view;
  logic [REG_DW-1:0]    rdata_nxt;
  logic [REG_DW-1:0]    rdata_r;

  // Firmware write-zero clears, one per hardware-set flag
  logic                 clr_tx_done;
  logic                 clr_out_b0;
  logic                 clr_setup;
  logic                 clr_stall_crc;
  logic                 clr_out_b1;

  // Transfer type decode
  assign is_iso     = (ep_type_r == EP_ISO);
  assign is_control = (ep_type_r == EP_CONTROL);

  // Register strobes
  assign status_wr = reg_wr && (reg_addr == STATUS_ADDR);
  assign config_wr = reg_wr && (reg_addr == CONFIG_ADDR);
  assign mask_wr   = reg_wr && (reg_addr == MASK_ADDR);
  assign event_rd  = reg_rd && (reg_addr == EVENT_ADDR);

  // Writing one keeps a flag, so firmware can clear a single flag
  // with a plain write without racing the hardware on the others
  assign clr_tx_done   = status_wr && !reg_wdata[TX_DONE_BIT];
  assign clr_out_b0    = status_wr && !reg_wdata[OUT_B0_BIT];
  assign clr_setup     = status_wr && !reg_wdata[SETUP_BIT];
  assign clr_stall_crc = status_wr && !reg_wdata[STALL_CRC_BIT];
  assign clr_out_b1    = status_wr && !reg_wdata[OUT_B1_BIT];

  // Hardware set conditions
  assign setup_set  = setup_rx_ok;
  assign stall_set  = stall_sent && stall_request_bit_r && !is_iso;
  assign crc_update = data_rx_done && is_iso;
  // Only a fresh error raises an event; a run of bad packets interrupts once
  assign crc_rise   = crc_update && data_crc_err && !stall_sent_crc_flag_r;
  // Bank select is forced to 0 unless ping-pong is on
  assign b0_set     = out_stored && !(ping_pong_r && out_stored_bank);
  assign b1_set     = out_stored && ping_pong_r && out_stored_bank;
  // Iso completes on transmission, others wait for the ACK
  assign in_done    = is_iso ? in_sent : in_acked;

  // Stall sent / CRC error flag; in iso mode it mirrors the last packet's CRC
  // Switching type keeps the flag, so firmware clears it after reconfiguring
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      stall_sent_crc_flag_r <= 1'b0;
    else if (setup_set)
      stall_sent_crc_flag_r <= 1'b0;
    else if (is_iso)
    begin
      // Software writes have no effect in iso mode
      if (crc_update)
        stall_sent_crc_flag_r <= data_crc_err;
    end
    else if (stall_set)
      stall_sent_crc_flag_r <= 1'b1;
    else if (clr_stall_crc)
      stall_sent_crc_flag_r <= 1'b0;
  end

  // Setup received flag; hardware never clears it
  // A second SETUP before the clear simply sets it again
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      setup_received_flag_r <= 1'b0;
    else if (setup_set)
      setup_received_flag_r <= 1'b1;
    else if (clr_setup)
      setup_received_flag_r <= 1'b0;
  end

  // OUT bank 0 flag
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      out_bank0_received_flag_r <= 1'b0;
    else if (setup_set)
      out_bank0_received_flag_r <= 1'b0;
    else if (b0_set)
      out_bank0_received_flag_r <= 1'b1;
    else if (clr_out_b0)
      out_bank0_received_flag_r <= 1'b0;
  end

  // OUT bank 1 flag, only reachable in ping-pong mode
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      out_bank1_received_flag_r <= 1'b0;
    else if (setup_set)
      out_bank1_received_flag_r <= 1'b0;
    else if (b1_set)
      out_bank1_received_flag_r <= 1'b1;
    else if (clr_out_b1)
      out_bank1_received_flag_r <= 1'b0;
  end

  // IN transmit complete flag
  // Cleared by firmware before it queues the next IN packet
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      in_transmit_complete_flag_r <= 1'b0;
    else if (setup_set)
      in_transmit_complete_flag_r <= 1'b0;
    else if (in_done)
      in_transmit_complete_flag_r <= 1'b1;
    else if (clr_tx_done)
      in_transmit_complete_flag_r <= 1'b0;
  end

  // IN packet ready; a firmware write in the completing cycle wins,
  // so a packet queued right then is not dropped
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      in_packet_ready_bit_r <= 1'b0;
    else if (setup_set)
      in_packet_ready_bit_r <= 1'b0;
    else if (status_wr)
      in_packet_ready_bit_r <= reg_wdata[IN_READY_BIT];
    else if (in_done)
      in_packet_ready_bit_r <= 1'b0;
  end

  // Stall request, held until firmware drops it or a SETUP arrives
  // A request written while a SETUP lands is lost; firmware must re-arm it
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      stall_request_bit_r <= 1'b0;
    else if (setup_set)
      stall_request_bit_r <= 1'b0;
    else if (status_wr)
      stall_request_bit_r <= reg_wdata[STALL_REQ_BIT];
  end

  // Endpoint configuration
  // Type changes take effect on the next packet; flags are not reset by them
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      ep_type_r   <= TYPE_RST;
      ping_pong_r <= 1'b0;
    end
    else if (config_wr)
    begin
      ep_type_r   <= ep_type_t'(reg_wdata[CFG_TYPE_MSB:CFG_TYPE_LSB]);
      ping_pong_r <= reg_wdata[CFG_PP_BIT];
    end
  end

  // NAK further OUT data to a bank still holding unread data;
  // iso endpoints never NAK and simply overwrite
  always_comb
  begin
    out_nak = 1'b0;
    if (out_token && !is_iso)
    begin
      if (ping_pong_r && out_token_bank)
        out_nak = out_bank1_received_flag_r;
      else
        out_nak = out_bank0_received_flag_r;
    end
  end

  // A SETUP on a control endpoint is never held back by the OUT flag
  assign setup_fifo_write_ok = setup_token && is_control;

  // Handshake levels from flip-flops
  assign stall_handshake_en = stall_request_bit_r;
  assign in_packet_ready    = in_packet_ready_bit_r;

  // Events: one bit per hardware-set flag, same layout as status
  // A SETUP outranks every other event in its cycle: the flags it wipes
  // must not leave an interrupt behind that points at nothing
  always_comb
  begin
    event_set                = '0;
    event_set[TX_DONE_BIT]   = in_done && !setup_set;
    event_set[OUT_B0_BIT]    = b0_set && !setup_set;
    event_set[SETUP_BIT]     = setup_set;
    event_set[STALL_CRC_BIT] = !setup_set && (stall_set || crc_rise);
    event_set[OUT_B1_BIT]    = b1_set && !setup_set;
  end

  // Sticky event bits, cleared by reading them
  sticky_bits #(
    .W         (REG_DW)
  ) u_events (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .set_bits  (event_set),
    .clear_all (event_rd),
    .bits_r    (event_r)
  );

  // Mask gates the events onto the interrupt line
  irq_gate u_irq (
    .ref_clk    (ref_clk),
    .rst_n      (rst_n),
    .mask_wr    (mask_wr),
    .mask_wdata (reg_wdata),
    .event_bits (event_r),
    .mask_r     (mask_r),
    .irq        (irq)
  );

  // Status view; unused bit 7 reads zero
  // Bits 4 and 5 are firmware-owned levels; the rest are hardware-set flags
  always_comb
  begin
    status_view                = '0;
    status_view[TX_DONE_BIT]   = in_transmit_complete_flag_r;
    status_view[OUT_B0_BIT]    = out_bank0_received_flag_r;
    status_view[SETUP_BIT]     = setup_received_flag_r;
    status_view[STALL_CRC_BIT] = stall_sent_crc_flag_r;
    status_view[IN_READY_BIT]  = in_packet_ready_bit_r;
    status_view[STALL_REQ_BIT] = stall_request_bit_r;
    status_view[OUT_B1_BIT]    = out_bank1_received_flag_r;
  end

  // Configuration view
  always_comb
  begin
    config_view                            = '0;
    config_view[CFG_TYPE_MSB:CFG_TYPE_LSB] = ep_type_r;
    config_view[CFG_PP_BIT]                = ping_pong_r;
  end

  // Read selection; the event value is taken before its clear lands
  always_comb
  begin
    rdata_nxt = READ_IDLE;
    if (reg_rd)
    begin
      unique case (reg_addr)
        STATUS_ADDR: rdata_nxt = status_view;
        CONFIG_ADDR: rdata_nxt = config_view;
        EVENT_ADDR:  rdata_nxt = event_r;
        MASK_ADDR:   rdata_nxt = mask_r;
      endcase
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      rdata_r <= READ_IDLE;
    else
      rdata_r <= rdata_nxt;
  end

  // Registered read port; idle cycles read zero so a stray sample is harmless
  assign reg_rdata = rdata_r;

endmodule // usb_endpoint_status_flags

/* hdl/usb_ep_pkg.sv */
// Shared constants and types for the endpoint status flag block
package usb_ep_pkg;

  // Register port geometry
  localparam int REG_AW = 2;
  localparam int REG_DW = 8;

  // Register addresses
  localparam logic [REG_AW-1:0] STATUS_ADDR = 2'h0;
  localparam logic [REG_AW-1:0] CONFIG_ADDR = 2'h1;
  localparam logic [REG_AW-1:0] EVENT_ADDR  = 2'h2;
  localparam logic [REG_AW-1:0] MASK_ADDR   = 2'h3;

  // Endpoint status register layout; event and mask registers share it
  localparam int TX_DONE_BIT   = 0;
  localparam int OUT_B0_BIT    = 1;
  localparam int SETUP_BIT     = 2;
  localparam int STALL_CRC_BIT = 3;
  localparam int IN_READY_BIT  = 4;
  localparam int STALL_REQ_BIT = 5;
  localparam int OUT_B1_BIT    = 6;

  // Configuration register layout
  localparam int CFG_TYPE_LSB = 0;
  localparam int CFG_TYPE_MSB = 1;
  localparam int CFG_PP_BIT   = 2;

  // Reset values
  localparam logic [REG_DW-1:0] MASK_RST   = 8'h00;
  localparam logic [REG_DW-1:0] READ_IDLE  = 8'h00;

  // Endpoint transfer type, as held in the configuration register
  typedef enum logic [1:0] {
    EP_CONTROL   = 2'h0,
    EP_ISO       = 2'h1,
    EP_BULK      = 2'h2,
    EP_INTERRUPT = 2'h3
  } ep_type_t;

  localparam ep_type_t TYPE_RST = EP_CONTROL;

endpackage
